// *** rtc_pkg.sv ***
// constants and types shared by the time-of-day core
package rtc_pkg;
	// register offsets
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL3 = 8'h02;
	localparam logic [7:0] ADDR_SEC   = 8'h03;
	localparam logic [7:0] ADDR_MIN   = 8'h04;
	localparam logic [7:0] ADDR_HR    = 8'h05;
	// field positions
	localparam int OSF_BIT    = 7;
	localparam int CLKEN_BIT  = 0;
	localparam int H12_BIT    = 2;
	localparam int ARM_BIT    = 3;
	localparam int BSW_BIT    = 0;
	localparam int BLOW_BIT   = 1;
	localparam int PFAIL_BIT  = 2;
	localparam int PM_BIT     = 5;
	// reset values and implemented-bit masks
	localparam logic [7:0] CTRL1_RST  = 8'h09;
	localparam logic [7:0] CTRL1_MASK = 8'h0d;
	localparam logic [7:0] CTRL3_RST  = 8'h07;
	localparam logic [7:0] CTRL3_MASK = 8'h07;
	// bcd limits
	localparam logic [6:0] BCD_59   = 7'h59;
	localparam logic [5:0] BCD_23   = 6'h23;
	localparam logic [4:0] BCD_12   = 5'h12;
	localparam logic [4:0] BCD_11   = 5'h11;
	localparam logic [3:0] BCD_9    = 4'h9;
	// register write carried across the link
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} wr_req_type;
	// reset-bypass pin sequence
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_LOW  = 2'b01,
		SEQ_CLK  = 2'b10,
		SEQ_DONE = 2'b11
	} seq_type;
endpackage

// *** rtc_time_core.sv ***
// reset control and time-of-day counters of the clock core
// Function
// - internal reset holds while the oscillator is not stable
// - every internal reset sets the oscillator-halt flag
// - leaving reset: clock out on, arm set, 24-hour, power monitors on
// - bypass entry needs arm bit and the pin toggle sequence
// - entering bypass mode ends internal reset one core clock later
// - writing arm bit 0 ends bypass; a later internal reset sets arm again
// - bypass entry accepted only while arm bit is 1
// - seconds bit 7 is the halt flag, reset value 1
// - seconds in BCD, tens bits 6-4, units bits 3-0
// - time counts are not cleared by any reset
// - minutes in BCD at 04h, bit 7 unused
// - unimplemented bits ignore writes and read as zero
// - 12-hour: hours 1-12 BCD, bit 5 marks afternoon
// - 24-hour: hours 0-23 BCD, tens in bits 5-4
// - hour format follows the select bit in control one
// - halt flag stays 1 until host writes 0 to it
// - counters frozen while a host access is in progress
// - one pending tick kept while frozen, serviced on release
`timescale 1ns/1ns
module rtc_time_core (
	// core clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// link side
	input  wire logic               i_link_clk,
	input  wire logic               i_link_access,
	input  wire logic               i_link_wr,
	input  wire rtc_pkg::wr_req_type i_link_req,
	output logic                    o_link_busy,
	// oscillator and serial pins
	input  wire logic               i_osc_stable,
	input  wire logic               i_tick_1hz,
	input  wire logic               i_sda_ce,
	input  wire logic               i_scl,
	// register contents
	output logic [7:0]              o_ctrl1,
	output logic [7:0]              o_ctrl3,
	output logic [7:0]              o_seconds,
	output logic [7:0]              o_minutes,
	output logic [7:0]              o_hours,
	// status and enables
	output logic                    o_int_reset,
	output logic                    o_bypass_mode,
	output logic                    o_day_carry,
	output logic                    o_clock_output_pin_en,
	output logic                    o_bat_switch_en,
	output logic                    o_bat_low_en,
	output logic                    o_pfail_en
);
	logic               req_tgl_ff;
	logic               ack_s1_ff, ack_s2_ff;
	rtc_pkg::wr_req_type req_ff;
	logic               rq_s1_ff, rq_s2_ff, rq_s3_ff;
	logic               acc_s1_ff, acc_s2_ff;
	logic               osc_s1_ff, osc_s2_ff;
	logic               tk_s1_ff, tk_s2_ff, tk_s3_ff;
	logic               sda_s1_ff, sda_s2_ff, scl_s1_ff, scl_s2_ff;
	logic               por_ff, bypass_ff, osf_ff, pend_ff, carry_ff;
	logic [7:0]         ctrl1_ff, ctrl3_ff;
	logic [6:0]         sec_ff, min_ff;
	logic [5:0]         hr_ff;
	rtc_pkg::seq_type   seq_ff, nxt_seq;
	logic               wr_pulse, tick_evt, frozen, advance, seq_en;
	logic               wr_ctrl1, wr_sec, wr_min, wr_hr, arm_clr;
	logic [7:0]         nxt_sec, nxt_min;
	logic [6:0]         nxt_hr;
	// link domain: hold the write until the core acknowledges it
	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			req_tgl_ff <= 1'b0;
			req_ff     <= '0;
		end else if (i_link_wr && !o_link_busy) begin
			req_tgl_ff <= ~req_tgl_ff;
			req_ff     <= i_link_req;
		end
	end

	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end else begin
			ack_s1_ff <= rq_s3_ff; // ack once the write has landed
			ack_s2_ff <= ack_s1_ff;
		end
	end
	// busy until the toggle comes back; a write while busy is dropped
	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			o_link_busy <= 1'b0;
		end else if (i_link_wr && !o_link_busy) begin
			o_link_busy <= 1'b1;
		end else begin
			o_link_busy <= (req_tgl_ff != ack_s2_ff);
		end
	end
	// core domain synchronisers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{rq_s1_ff, rq_s2_ff, rq_s3_ff} <= 3'h0;
			{acc_s1_ff, acc_s2_ff} <= 2'h0;
			{osc_s1_ff, osc_s2_ff} <= 2'h0;
			{tk_s1_ff, tk_s2_ff, tk_s3_ff} <= 3'h0;
			{sda_s1_ff, sda_s2_ff, scl_s1_ff, scl_s2_ff} <= 4'hf;
		end else begin
			{rq_s1_ff, rq_s2_ff, rq_s3_ff} <= {req_tgl_ff, rq_s1_ff, rq_s2_ff};
			{acc_s1_ff, acc_s2_ff} <= {i_link_access, acc_s1_ff};
			{osc_s1_ff, osc_s2_ff} <= {i_osc_stable, osc_s1_ff};
			{tk_s1_ff, tk_s2_ff, tk_s3_ff} <= {i_tick_1hz, tk_s1_ff, tk_s2_ff};
			{sda_s1_ff, sda_s2_ff} <= {i_sda_ce, sda_s1_ff};
			{scl_s1_ff, scl_s2_ff} <= {i_scl, scl_s1_ff};
		end
	end
	// request data is stable while the toggle is in flight
	assign wr_pulse = rq_s2_ff ^ rq_s3_ff;
	assign tick_evt = tk_s2_ff & ~tk_s3_ff;
	assign frozen   = acc_s2_ff;
	assign wr_ctrl1 = wr_pulse && req_ff.addr == rtc_pkg::ADDR_CTRL1;
	assign wr_sec   = wr_pulse && req_ff.addr == rtc_pkg::ADDR_SEC;
	assign wr_min   = wr_pulse && req_ff.addr == rtc_pkg::ADDR_MIN;
	assign wr_hr    = wr_pulse && req_ff.addr == rtc_pkg::ADDR_HR;
	assign arm_clr  = wr_ctrl1 && !req_ff.data[rtc_pkg::ARM_BIT];
	assign seq_en   = por_ff && ctrl1_ff[rtc_pkg::ARM_BIT];
	assign advance  = !por_ff && !frozen && (tick_evt || pend_ff);
	// internal reset follows the oscillator unless bypassed
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			por_ff <= 1'b1;
		end else if (bypass_ff) begin
			por_ff <= 1'b0;
		end else begin
			por_ff <= ~osc_s2_ff;
		end
	end
	// pin sequence: data low with clock high, clock low, clock high
	always_comb begin
		nxt_seq = seq_ff;
		case (seq_ff)
			rtc_pkg::SEQ_IDLE: begin
				if (scl_s2_ff && !sda_s2_ff) begin
					nxt_seq = rtc_pkg::SEQ_LOW;
				end
			end
			rtc_pkg::SEQ_LOW: begin
				if (sda_s2_ff) begin
					nxt_seq = rtc_pkg::SEQ_IDLE;
				end else if (!scl_s2_ff) begin
					nxt_seq = rtc_pkg::SEQ_CLK;
				end
			end
			rtc_pkg::SEQ_CLK: begin
				if (scl_s2_ff) begin
					nxt_seq = rtc_pkg::SEQ_DONE;
				end
			end
			default: begin
				nxt_seq = rtc_pkg::SEQ_IDLE;
			end
		endcase
		if (!seq_en) begin
			nxt_seq = rtc_pkg::SEQ_IDLE;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			seq_ff <= rtc_pkg::SEQ_IDLE;
		end else begin
			seq_ff <= nxt_seq;
		end
	end
	// bypass mode; clearing the arm bit wins over a new entry
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bypass_ff <= 1'b0;
		end else if (arm_clr) begin
			bypass_ff <= 1'b0;
		end else if (seq_ff == rtc_pkg::SEQ_DONE && seq_en) begin
			bypass_ff <= 1'b1;
		end
	end

	// control registers stay at defaults while reset holds
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl1_ff <= rtc_pkg::CTRL1_RST;
			ctrl3_ff <= rtc_pkg::CTRL3_RST;
		end else if (por_ff) begin
			ctrl1_ff <= rtc_pkg::CTRL1_RST;
			ctrl3_ff <= rtc_pkg::CTRL3_RST;
		end else if (wr_ctrl1) begin
			ctrl1_ff <= req_ff.data & rtc_pkg::CTRL1_MASK;
		end else if (wr_pulse && req_ff.addr == rtc_pkg::ADDR_CTRL3) begin
			ctrl3_ff <= req_ff.data & rtc_pkg::CTRL3_MASK;
		end
	end

	// halt flag: a reset in the clearing cycle still sets it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			osf_ff <= 1'b1;
		end else if (por_ff) begin
			osf_ff <= 1'b1;
		end else if (wr_sec && !req_ff.data[rtc_pkg::OSF_BIT]) begin
			osf_ff <= 1'b0;
		end
	end

	// only one tick is remembered; a second one while frozen is lost
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_ff <= 1'b0;
		end else if (por_ff || !frozen) begin
			pend_ff <= 1'b0;
		end else if (tick_evt) begin
			pend_ff <= 1'b1;
		end
	end

	// bcd carry chain
	always_comb begin
		nxt_sec = {1'b0, sec_ff + 7'h01};
		nxt_min = {1'b0, min_ff + 7'h01};
		if (sec_ff == rtc_pkg::BCD_59) begin
			nxt_sec = 8'h80;
		end else if (sec_ff[3:0] == rtc_pkg::BCD_9) begin
			nxt_sec = {1'b0, sec_ff[6:4] + 3'h1, 4'h0};
		end
		if (min_ff == rtc_pkg::BCD_59) begin
			nxt_min = 8'h80;
		end else if (min_ff[3:0] == rtc_pkg::BCD_9) begin
			nxt_min = {1'b0, min_ff[6:4] + 3'h1, 4'h0};
		end
		nxt_hr = {1'b0, hr_ff + 6'h01};
		if (ctrl1_ff[rtc_pkg::H12_BIT]) begin
			if (hr_ff[4:0] == rtc_pkg::BCD_12) begin
				nxt_hr = {1'b0, hr_ff[rtc_pkg::PM_BIT], 1'b0, 4'h1};
			end else if (hr_ff[4:0] == rtc_pkg::BCD_11) begin
				nxt_hr = {hr_ff[rtc_pkg::PM_BIT], ~hr_ff[rtc_pkg::PM_BIT],
					rtc_pkg::BCD_12};
			end else if (hr_ff[3:0] == rtc_pkg::BCD_9) begin
				nxt_hr = {1'b0, hr_ff[rtc_pkg::PM_BIT], 1'b1, 4'h0};
			end
		end else begin
			if (hr_ff == rtc_pkg::BCD_23) begin
				nxt_hr = 7'h40;
			end else if (hr_ff[3:0] == rtc_pkg::BCD_9) begin
				nxt_hr = {1'b0, hr_ff[5:4] + 2'h1, 4'h0};
			end
		end
	end

	// counts have no reset and keep their value through resets
	always_ff @(posedge i_clk) begin
		if (wr_sec) begin
			sec_ff <= req_ff.data[6:0];
		end else if (advance) begin
			sec_ff <= nxt_sec[6:0];
		end
		if (wr_min) begin
			min_ff <= req_ff.data[6:0];
		end else if (advance && nxt_sec[7]) begin
			min_ff <= nxt_min[6:0];
		end
		if (wr_hr) begin
			hr_ff <= req_ff.data[5:0];
		end else if (advance && nxt_sec[7] && nxt_min[7]) begin
			hr_ff <= nxt_hr[5:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			carry_ff <= 1'b0;
		end else begin
			carry_ff <= advance && nxt_sec[7] && nxt_min[7] && nxt_hr[6];
		end
	end

	assign o_ctrl1   = ctrl1_ff;
	assign o_ctrl3   = ctrl3_ff;
	assign o_seconds = {osf_ff, sec_ff};
	assign o_minutes = {1'b0, min_ff};
	assign o_hours   = {2'b00, hr_ff};
	assign o_int_reset   = por_ff;
	assign o_bypass_mode = bypass_ff;
	assign o_day_carry   = carry_ff;
	assign o_clock_output_pin_en = ctrl1_ff[rtc_pkg::CLKEN_BIT];
	assign o_bat_switch_en = ctrl3_ff[rtc_pkg::BSW_BIT];
	assign o_bat_low_en    = ctrl3_ff[rtc_pkg::BLOW_BIT];
	assign o_pfail_en      = ctrl3_ff[rtc_pkg::PFAIL_BIT];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	por_hold_a: assert property (!osc_s2_ff && !bypass_ff |=> por_ff)
		else $error("internal reset released while oscillator stopped");
	osf_set_a: assert property (por_ff |=> osf_ff)
		else $error("halt flag not set by internal reset");
	ctrl_dflt_a: assert property ($fell(por_ff) |->
		ctrl1_ff == rtc_pkg::CTRL1_RST && ctrl3_ff == rtc_pkg::CTRL3_RST)
		else $error("control defaults wrong on reset exit");
	byp_exit_a: assert property ($rose(bypass_ff) |=> !por_ff)
		else $error("bypass did not end internal reset");
	arm_clear_a: assert property (arm_clr |=> !bypass_ff)
		else $error("arm clear did not end bypass");
	byp_gate_a: assert property ($rose(bypass_ff) |->
		$past(ctrl1_ff[rtc_pkg::ARM_BIT]) && $past(seq_ff) == rtc_pkg::SEQ_DONE)
		else $error("bypass entered without arm");
	frz_hold_a: assert property (frozen && !wr_sec ##1 frozen && !wr_sec
		|-> $stable(sec_ff))
		else $error("seconds moved while frozen");
	pend_svc_a: assert property (frozen && tick_evt && !por_ff ##1
		!frozen && !por_ff |-> advance)
		else $error("pending tick not serviced on release");
	sec_wrap_a: assert property (advance && !wr_sec && !wr_min &&
		sec_ff == rtc_pkg::BCD_59 |=> sec_ff == 7'h00 && $changed(min_ff))
		else $error("seconds wrap did not carry");
	hr24_wrap_a: assert property (advance && !wr_hr && nxt_sec[7] &&
		nxt_min[7] && !ctrl1_ff[rtc_pkg::H12_BIT] && hr_ff == rtc_pkg::BCD_23
		|=> hr_ff == 6'h00 && o_day_carry)
		else $error("24-hour wrap wrong");
	rst_stall_a: assert property (por_ff && !wr_sec |=> $stable(sec_ff))
		else $error("seconds advanced in reset");
	unused_a: assert property (o_minutes[7] == 1'b0 &&
		o_hours[7:6] == 2'b00)
		else $error("unused bits read nonzero");

	byp_cov_c: cover property ($rose(bypass_ff));
	carry_cov_c: cover property (o_day_carry);
	pend_cov_c: cover property (pend_ff ##1 advance);
endmodule

// *** rtc_host_model.sv ***
// host-side link model: write frames and read frames
`timescale 1ns/1ns
module rtc_host_model (
	// raw link clock, reset and design answer
	input  wire logic           i_raw_clk,
	input  wire logic           i_rst,
	input  wire logic           i_link_busy,
	// link drive
	output logic                o_link_clk,
	output logic                o_link_access,
	output logic                o_link_wr,
	output rtc_pkg::wr_req_type o_link_req
);
	logic run;
	// clock stands still between frames but must tick through reset
	assign o_link_clk = i_raw_clk & (run | i_rst);
	initial begin
		run = 1'b0;
		o_link_access = 1'b0;
		o_link_wr = 1'b0;
		o_link_req = 16'h0000;
	end
	task automatic frame(input logic wr, input logic [7:0] a,
		input logic [7:0] d, input int hold);
		int n;
		@(negedge i_raw_clk);
		run = 1'b1;
		o_link_access = 1'b1;
		@(negedge i_raw_clk);
		o_link_wr = wr;
		o_link_req = {a, d};
		@(posedge o_link_clk);
		@(negedge i_raw_clk);
		o_link_wr = 1'b0;
		// released request lines do not keep the last value
		o_link_req = ~{a, d};
		n = 0;
		// access ends in a bounded span, far inside one second
		while ((i_link_busy !== 1'b0 || n < hold) && n < 200) begin
			@(negedge i_raw_clk);
			n++;
		end
		o_link_access = 1'b0;
		@(negedge i_raw_clk);
		run = 1'b0;
	endtask
endmodule

// *** rtc_reset_and_time_of_day_tb_top.sv ***
// testbench for the reset control and time-of-day core
`timescale 1ns/1ns
module rtc_reset_and_time_of_day_tb_top;
	logic                i_clk, i_rst, raw_clk, osc, tick, sda, scl;
	logic                link_clk, access, wr, busy, carry;
	logic                int_reset, bypass, clk_en, bsw, blow, pfail;
	rtc_pkg::wr_req_type req;
	logic [7:0]          ctrl1, ctrl3, sec, mins, hrs;
	int                  num_errors = 0;
	int                  checked = 0;
	int                  carries = 0;
	rtc_host_model host (.i_raw_clk(raw_clk), .i_rst(i_rst),
		.i_link_busy(busy), .o_link_clk(link_clk),
		.o_link_access(access), .o_link_wr(wr), .o_link_req(req));
	rtc_time_core dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_link_clk(link_clk), .i_link_access(access),
		.i_link_wr(wr), .i_link_req(req), .o_link_busy(busy),
		.i_osc_stable(osc), .i_tick_1hz(tick), .i_sda_ce(sda),
		.i_scl(scl), .o_ctrl1(ctrl1), .o_ctrl3(ctrl3),
		.o_seconds(sec), .o_minutes(mins), .o_hours(hrs),
		.o_int_reset(int_reset), .o_bypass_mode(bypass),
		.o_day_carry(carry), .o_clock_output_pin_en(clk_en),
		.o_bat_switch_en(bsw), .o_bat_low_en(blow),
		.o_pfail_en(pfail));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// link clock unrelated in phase to the core clock
	initial begin
		raw_clk = 1'b0;
		forever begin
			#8 raw_clk = 1'b1;
			#7 raw_clk = 1'b0;
		end
	end
	always @(posedge i_clk) begin
		if (carry === 1'b1)
			carries++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		host.frame(1'b1, a, d, 4);
	endtask
	task automatic pulse;
		@(negedge i_clk);
		tick = 1'b1;
		repeat (6) @(negedge i_clk);
		tick = 1'b0;
		repeat (8) @(negedge i_clk);
	endtask
	task automatic pins(input logic s, input logic c);
		@(negedge i_clk);
		sda = s;
		scl = c;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic roll(input logic [7:0] h);
		wreg(rtc_pkg::ADDR_SEC, 8'h59);
		wreg(rtc_pkg::ADDR_MIN, 8'h59);
		wreg(rtc_pkg::ADDR_HR, h);
		pulse();
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		i_rst = 1'b1;
		osc = 1'b0;
		tick = 1'b0;
		sda = 1'b1;
		scl = 1'b1;
		repeat (2) @(negedge i_clk);
		chk({7'h00, int_reset}, 8'h01);
		chk(sec & 8'h80, 8'h80);
		chk(ctrl1, 8'h09);
		chk(ctrl3, 8'h07);
		i_rst = 1'b0;
		// first host access; the fuse refresh is outside this core
		// halt flag clear is not honoured while still in reset
		wreg(rtc_pkg::ADDR_SEC, 8'h58);
		chk(sec, 8'hd8);
		pulse();
		chk(sec, 8'hd8);
		chk({7'h00, int_reset}, 8'h01);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		// reset drops one core edge after bypass is taken
		repeat (2) @(negedge i_clk);
		chk({6'h00, bypass, int_reset}, 8'h02);
		chk({4'h0, clk_en, bsw, blow, pfail}, 8'h0f);
		chk(ctrl1, 8'h09);
		pulse();
		chk(sec, 8'hd9);
		wreg(rtc_pkg::ADDR_CTRL1, 8'h01);
		chk({7'h00, bypass}, 8'h00);
		osc = 1'b1;
		repeat (10) @(negedge i_clk);
		chk({7'h00, int_reset}, 8'h00);
		wreg(rtc_pkg::ADDR_CTRL1, 8'h01);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		chk({7'h00, bypass}, 8'h00);
		wreg(rtc_pkg::ADDR_SEC, 8'h59);
		chk(sec, 8'h59);
		wreg(rtc_pkg::ADDR_MIN, 8'hd9);
		chk(mins, 8'h59);
		wreg(rtc_pkg::ADDR_HR, 8'he3);
		chk(hrs, 8'h23);
		carries = 0;
		pulse();
		chk(sec | mins | hrs, 8'h00);
		chk(carries[7:0], 8'h01);
		// 12-hour: 11 AM rolls to 12 PM, 11 PM rolls to 12 AM
		wreg(rtc_pkg::ADDR_CTRL1, 8'h05);
		wreg(rtc_pkg::ADDR_SEC, 8'h59);
		wreg(rtc_pkg::ADDR_MIN, 8'h59);
		wreg(rtc_pkg::ADDR_HR, 8'h11);
		pulse();
		chk(hrs, 8'h32);
		chk(carries[7:0], 8'h01);
		wreg(rtc_pkg::ADDR_SEC, 8'h59);
		wreg(rtc_pkg::ADDR_MIN, 8'h59);
		wreg(rtc_pkg::ADDR_HR, 8'h31);
		pulse();
		chk(hrs, 8'h12);
		chk(carries[7:0], 8'h02);
		// 12 PM rolls to 01 PM, 09 PM rolls to 10 PM
		roll(8'h32);
		chk(hrs, 8'h21);
		roll(8'h29);
		chk(hrs, 8'h30);
		// two ticks inside one access: only one is kept
		wreg(rtc_pkg::ADDR_SEC, 8'h10);
		chk({7'h00, busy}, 8'h00);
		fork
			host.frame(1'b0, 8'h00, 8'h00, 150);
			begin
				repeat (3) @(negedge i_clk);
				pulse();
				pulse();
				chk(sec, 8'h10);
			end
		join
		repeat (8) @(negedge i_clk);
		chk(sec, 8'h11);
		@(negedge i_clk);
		i_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		chk(sec, 8'h91);
		chk(hrs, 8'h30);
		i_rst = 1'b0;
		end_of_test();
	end
endmodule
